/* logic/two_wire_pkg.sv */
// Shared constants for the write-only two-wire configuration port and its master.
package two_wire_pkg;

  // Link framing.
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] DEV_ADDR_BYTE = 8'h98;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_REG = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;

  // Configuration register indices.
  localparam logic [7:0] REG_CHARGE = 8'h00;
  localparam logic [7:0] REG_SYSPATH = 8'h01;
  localparam logic [7:0] REG_LDO = 8'h02;
  localparam logic [7:0] REG_LAST = 8'h02;
  localparam int REG_COUNT = 3;

  // Reset values: every field starts at its default code.
  localparam logic [7:0] CHARGE_RST = 8'h00;
  localparam logic [7:0] SYSPATH_RST = 8'h00;
  localparam logic [7:0] LDO_RST = 8'h00;

  // Implemented bits per register; unused bits are stored as zero.
  localparam logic [7:0] CHARGE_MASK = 8'hff;
  localparam logic [7:0] SYSPATH_MASK = 8'h07;
  localparam logic [7:0] LDO_MASK = 8'hff;

  // Field positions in the charge register.
  localparam int TERM_LSB = 0;
  localparam int CHG_LSB = 2;
  localparam int RCHG_LSB = 5;
  localparam int TIMER_BIT = 7;
  // Field positions in the system path register.
  localparam int LDO1_LSB = 0;
  localparam int SYS_BIT = 2;
  // Field positions in the LDO register.
  localparam int LDO2_LSB = 0;
  localparam int LDO3_LSB = 2;
  localparam int LDO4_LSB = 4;
  localparam int LDO5_LSB = 6;

  // Timing of the master-made link clock.
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int QTR_CYC = (LINK_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : two_wire_pkg

/* logic/two_wire_if.sv */
// Open-drain two-wire link joining the configuration port and its master.
`timescale 1ns/100ps
interface two_wire_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // A line is low when any party enables a low drive; pull-ups give high otherwise.
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);

  modport device (
    input scl,
    input sda,
    output d_sda_o,
    output d_sda_oe
  );

  modport master (
    input scl,
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );
endinterface : two_wire_if

/* logic/cfg_port.sv */
// Device end: write-only two-wire slave holding three configuration registers.
// Notes on behaviour
// R1: Writes only; nothing is ever read back.
// R2: Master always sends direction bit zero.
// R3: Answer only to address byte 0x98.
// R4: Bytes are eight bits, most significant first.
// R5: Ninth clock: master releases, device pulls low.
// R6: Only master makes START/STOP, from idle.
// R7: START: data falls while clock high.
// R8: STOP: clock rises, then data rises.
// R9: Address, register select, then data byte.
// R10: Level fields reset to default, change by write.
// R11: Registers 0x00..0x02; charge code bits 4:2.
// R12: Values held until shutdown clears them.
// R13: Wrong address: stay released, ignore rest.
`timescale 1ns/100ps
module cfg_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Shutdown from the enable logic, core_clk domain
  input wire logic cfg_clear,
  // Link
  two_wire_if.device link,
  // Charger settings
  output logic [1:0] term_code,
  output logic [2:0] chg_code,
  output logic [1:0] rchg_code,
  output logic timer_off,
  // Power path and LDO levels
  output logic sys_from_bat,
  output logic [1:0] ldo1_code,
  output logic [1:0] ldo2_code,
  output logic [1:0] ldo3_code,
  output logic [1:0] ldo4_code,
  output logic [1:0] ldo5_code,
  // Write notification
  output logic wr_pulse,
  output logic [7:0] wr_index
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_ACK,
    ST_SKIP
  } state_t;

  function automatic logic [7:0] reg_mask(input logic [7:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == two_wire_pkg::REG_CHARGE) begin
      m = two_wire_pkg::CHARGE_MASK;
    end else if (idx == two_wire_pkg::REG_SYSPATH) begin
      m = two_wire_pkg::SYSPATH_MASK;
    end else if (idx == two_wire_pkg::REG_LDO) begin
      m = two_wire_pkg::LDO_MASK;
    end
    return m;
  endfunction : reg_mask

  function automatic logic [7:0] reg_reset(input int idx);
    logic [7:0] v;
    v = two_wire_pkg::LDO_RST;
    if (idx == 0) begin
      v = two_wire_pkg::CHARGE_RST;
    end else if (idx == 1) begin
      v = two_wire_pkg::SYSPATH_RST;
    end
    return v;
  endfunction : reg_reset

  // Two-stage synchronisers plus one delay stage for edge finding.
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_d_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_d_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  assign start_seen = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r; // R7
  assign stop_seen = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r; // R8

  state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [1:0] byte_idx_r;
  logic [7:0] reg_sel_r;

  // A complete byte has been shifted and its eighth clock has ended.
  logic byte_done;
  logic byte_ok;

  assign byte_done = (state_r == ST_SHIFT) && scl_fall && (bit_cnt_r == two_wire_pkg::ACK_SLOT);

  always_comb begin
    byte_ok = 1'b0;
    if (byte_idx_r == two_wire_pkg::BYTE_ADDR) begin
      byte_ok = (shift_r == two_wire_pkg::DEV_ADDR_BYTE); // R3 R2 R13
    end else if (byte_idx_r == two_wire_pkg::BYTE_REG) begin
      byte_ok = (shift_r <= two_wire_pkg::REG_LAST); // R11
    end else if (byte_idx_r == two_wire_pkg::BYTE_DATA) begin
      byte_ok = 1'b1;
    end
  end

  logic ack_end;
  assign ack_end = (state_r == ST_ACK) && scl_fall;

  // Protocol sequencing. START is honoured in any state, so a repeated START restarts the frame.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= two_wire_pkg::BYTE_ADDR;
    end else if (start_seen) begin
      state_r <= ST_SHIFT;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= two_wire_pkg::BYTE_ADDR;
    end else if (stop_seen) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_SHIFT: begin
          if (scl_rise && bit_cnt_r != two_wire_pkg::ACK_SLOT) begin
            bit_cnt_r <= bit_cnt_r + 4'h1; // R4
          end else if (byte_done) begin
            bit_cnt_r <= 4'h0;
            state_r <= byte_ok ? ST_ACK : ST_SKIP; // R13
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            // Only one data byte per frame; later bytes go unanswered.
            if (byte_idx_r == two_wire_pkg::BYTE_DATA) begin
              state_r <= ST_SKIP; // R9
            end else begin
              state_r <= ST_SHIFT; // R9
              byte_idx_r <= byte_idx_r + 2'h1;
            end
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Data is taken on the rising clock, most significant bit first.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= 8'h00;
    end else if (state_r == ST_SHIFT && scl_rise && bit_cnt_r != two_wire_pkg::ACK_SLOT) begin
      shift_r <= {shift_r[6:0], sda_s2_r}; // R4
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_sel_r <= 8'h00;
    end else if (byte_done && byte_ok && byte_idx_r == two_wire_pkg::BYTE_REG) begin
      reg_sel_r <= shift_r;
    end
  end

  // Acknowledge drive: low from the eighth falling clock to the ninth falling clock.
  // The pin only ever pulls low, which is also why no read data can leave the block.
  logic sda_oe_r;
  logic sda_o_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe_r <= 1'b0;
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0; // R1
      if (start_seen || stop_seen) begin
        sda_oe_r <= 1'b0;
      end else if (byte_done && byte_ok) begin
        sda_oe_r <= 1'b1; // R5
      end else if (ack_end) begin
        sda_oe_r <= 1'b0; // R5
      end
    end
  end

  assign link.d_sda_oe = sda_oe_r;
  assign link.d_sda_o = sda_o_r;

  // Configuration store. Contents survive link activity and clear only on shutdown.
  logic [7:0] cfg_r [two_wire_pkg::REG_COUNT];
  logic wr_go;
  assign wr_go = ack_end && (byte_idx_r == two_wire_pkg::BYTE_DATA) && !start_seen && !stop_seen;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < two_wire_pkg::REG_COUNT; i++) begin
        cfg_r[i] <= reg_reset(i); // R10
      end
    end else if (cfg_clear) begin
      for (int i = 0; i < two_wire_pkg::REG_COUNT; i++) begin
        cfg_r[i] <= reg_reset(i); // R12
      end
    end else if (wr_go) begin
      cfg_r[reg_sel_r[1:0]] <= shift_r & reg_mask(reg_sel_r); // R10 R11
    end
  end

  logic wr_pulse_r;
  logic [7:0] wr_index_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pulse_r <= 1'b0;
      wr_index_r <= 8'h00;
    end else begin
      wr_pulse_r <= wr_go && !cfg_clear;
      if (wr_go && !cfg_clear) begin
        wr_index_r <= reg_sel_r;
      end
    end
  end

  assign wr_pulse = wr_pulse_r;
  assign wr_index = wr_index_r;

  // Field outputs are plain bit slices of the store.
  assign term_code = cfg_r[0][two_wire_pkg::TERM_LSB +: 2];
  assign chg_code = cfg_r[0][two_wire_pkg::CHG_LSB +: 3]; // R11
  assign rchg_code = cfg_r[0][two_wire_pkg::RCHG_LSB +: 2];
  assign timer_off = cfg_r[0][two_wire_pkg::TIMER_BIT];
  assign ldo1_code = cfg_r[1][two_wire_pkg::LDO1_LSB +: 2];
  assign sys_from_bat = cfg_r[1][two_wire_pkg::SYS_BIT];
  assign ldo2_code = cfg_r[2][two_wire_pkg::LDO2_LSB +: 2];
  assign ldo3_code = cfg_r[2][two_wire_pkg::LDO3_LSB +: 2];
  assign ldo4_code = cfg_r[2][two_wire_pkg::LDO4_LSB +: 2];
  assign ldo5_code = cfg_r[2][two_wire_pkg::LDO5_LSB +: 2];

endmodule : cfg_port

/* logic/cfg_master.sv */
// Master end: sends one address, register-select and data frame per request.
`timescale 1ns/100ps
module cfg_master #(
  parameter int QTR_CYC = two_wire_pkg::QTR_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request
  input wire logic go,
  input wire logic [7:0] go_reg,
  input wire logic [7:0] go_data,
  // Status
  output logic busy,
  output logic done,
  output logic nack,
  // Link
  two_wire_if.master link
);

  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_STOP
  } mstate_t;

  mstate_t state_r;
  logic [7:0] tq_r;
  logic [1:0] qtr_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] reg_q_r;
  logic [7:0] data_q_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic busy_r;
  logic done_r;
  logic nack_r;
  logic sda_s1_r;
  logic sda_s2_r;

  function automatic logic [7:0] frame_byte(input logic [1:0] idx, input logic [7:0] r, input logic [7:0] d);
    logic [7:0] b;
    b = d;
    if (idx == two_wire_pkg::BYTE_ADDR) begin
      b = two_wire_pkg::DEV_ADDR_BYTE; // R2 R3
    end else if (idx == two_wire_pkg::BYTE_REG) begin
      b = r; // R9
    end
    return b;
  endfunction : frame_byte

  logic qtick;
  logic [7:0] cur_byte;
  logic cur_bit;
  assign qtick = (tq_r == 8'h00);
  assign cur_byte = frame_byte(byte_r, reg_q_r, data_q_r);
  assign cur_bit = cur_byte[3'(7 - bit_r[2:0])]; // R4

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  // Quarter-period divider for the link clock, running only while a frame is active.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tq_r <= 8'h00;
    end else if (state_r == M_IDLE || qtick) begin
      tq_r <= 8'(QTR_CYC - 1);
    end else begin
      tq_r <= tq_r - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= M_IDLE;
      qtr_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      reg_q_r <= 8'h00;
      data_q_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        M_IDLE: begin
          if (go) begin
            state_r <= M_START; // R6
            qtr_r <= 2'h0;
            reg_q_r <= go_reg;
            data_q_r <= go_data;
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b1; // R7
          end
        end
        M_START: begin
          if (qtick) begin
            scl_oe_r <= 1'b1; // R7
            state_r <= M_BIT;
            qtr_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= two_wire_pkg::BYTE_ADDR;
          end
        end
        M_BIT: begin
          if (qtick) begin
            qtr_r <= qtr_r + 2'h1;
            if (qtr_r == 2'h0) begin
              // Ninth slot: the line is left to the device.
              sda_oe_r <= (bit_r == two_wire_pkg::ACK_SLOT) ? 1'b0 : !cur_bit; // R5
            end else if (qtr_r == 2'h1) begin
              scl_oe_r <= 1'b0;
            end else if (qtr_r == 2'h3) begin
              scl_oe_r <= 1'b1;
              if (bit_r != two_wire_pkg::ACK_SLOT) begin
                bit_r <= bit_r + 4'h1;
              end else begin
                bit_r <= 4'h0;
                if (sda_s2_r || byte_r == two_wire_pkg::BYTE_DATA) begin
                  nack_r <= sda_s2_r;
                  state_r <= M_STOP;
                  qtr_r <= 2'h0;
                end else begin
                  byte_r <= byte_r + 2'h1; // R9
                end
              end
            end
          end
        end
        default: begin
          if (qtick) begin
            qtr_r <= qtr_r + 2'h1;
            if (qtr_r == 2'h0) begin
              sda_oe_r <= 1'b1;
            end else if (qtr_r == 2'h1) begin
              scl_oe_r <= 1'b0; // R8
            end else if (qtr_r == 2'h2) begin
              sda_oe_r <= 1'b0; // R8
              state_r <= M_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign link.m_scl_oe = scl_oe_r;
  assign link.m_sda_oe = sda_oe_r;
  assign busy = busy_r;
  assign done = done_r;
  assign nack = nack_r;

endmodule : cfg_master

/* dv/two_wire_assertions.sv */
// Checker watching the link between the master end and the configuration port.
`timescale 1ns/100ps
module two_wire_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_r;
  logic sda_q_r;
  logic [4:0] rise_cnt_r;
  logic start;
  logic stop;
  logic rise;
  assign start = scl && scl_q_r && sda_q_r && !sda;
  assign stop = scl && scl_q_r && !sda_q_r && sda;
  assign rise = scl && !scl_q_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end
  // Counts clock rises since the last START, so each rise names its bit slot.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rise_cnt_r <= 5'h00;
    end else if (start) begin
      rise_cnt_r <= 5'h00;
    end else if (rise && rise_cnt_r != 5'h1f) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  open_drain_low_a: assert property (!m_scl_o && !m_sda_o && !d_sda_o)
    else $error("a line driver drives high");
  ack_slot_only_a: assert property (d_sda_oe && rise |-> rise_cnt_r inside {5'h08, 5'h11, 5'h1a})
    else $error("device pulls data outside an acknowledge slot");
  ack_hold_a: assert property ($rose(d_sda_oe) |-> d_sda_oe [*7])
    else $error("acknowledge released too early");
  ack_master_free_a: assert property ($rose(d_sda_oe) |-> !m_sda_oe)
    else $error("master still drives data at acknowledge");
  dir_bit_zero_a: assert property (rise && rise_cnt_r == 5'h07 |-> !sda)
    else $error("direction bit not zero");
  start_by_master_a: assert property (start |-> m_sda_oe && !m_scl_oe)
    else $error("start not made by the master");
  // The master may only open a frame from an idle bus, both lines released high.
  start_from_idle_a: assert property ($rose(m_sda_oe) && !m_scl_oe |-> $past(scl) && $past(sda))
    else $error("start begun on a bus that was not idle");
  stop_released_a: assert property (stop |-> !m_scl_oe && !m_sda_oe && !d_sda_oe)
    else $error("lines not released at stop");
  stop_slot_a: assert property (stop |-> rise_cnt_r inside {5'h0a, 5'h13, 5'h1c})
    else $error("stop at an unexpected bit slot");
  cover property (d_sda_oe && rise && rise_cnt_r == 5'h1a);
  cover property (stop && rise_cnt_r == 5'h1c);
  cover property (stop && rise_cnt_r == 5'h13);
endmodule : two_wire_assertions

/* dv/write_only_serial_config_port_bench.sv */
// Testbench joining the master and the port, plus a bench-driven second link.
`timescale 1ns/100ps
module write_only_serial_config_port_bench;
  logic core_clk;
  logic rstn;
  logic cfg_clear;
  logic go;
  logic [7:0] go_reg;
  logic [7:0] go_data;
  logic busy;
  logic done;
  logic nack;
  wire [7:0] a0;
  wire [2:0] a1;
  wire [7:0] a2;
  wire [7:0] b0;
  wire [2:0] b1;
  wire [7:0] b2;
  logic wr_pulse_a;
  logic [7:0] wr_index_a;
  logic [27:0] sh;
  logic [7:0] wr_idx_last;
  int wr_seen;
  int errors;
  int cmp_count;
  int cyc;
  two_wire_if link_a();
  two_wire_if link_b();
  cfg_master #(.QTR_CYC(2)) cfg_master_i (.core_clk(core_clk), .rstn(rstn), .go(go), .go_reg(go_reg),
    .go_data(go_data), .busy(busy), .done(done), .nack(nack), .link(link_a));
  cfg_port cfg_port_i (.core_clk(core_clk), .rstn(rstn), .cfg_clear(cfg_clear), .link(link_a),
    .term_code(a0[1:0]), .chg_code(a0[4:2]), .rchg_code(a0[6:5]), .timer_off(a0[7]),
    .sys_from_bat(a1[2]), .ldo1_code(a1[1:0]), .ldo2_code(a2[1:0]), .ldo3_code(a2[3:2]),
    .ldo4_code(a2[5:4]), .ldo5_code(a2[7:6]), .wr_pulse(wr_pulse_a), .wr_index(wr_index_a));
  // The second port faces the bench, which can send what the master never would.
  cfg_port cfg_port_b_i (.core_clk(core_clk), .rstn(rstn), .cfg_clear(cfg_clear), .link(link_b),
    .term_code(b0[1:0]), .chg_code(b0[4:2]), .rchg_code(b0[6:5]), .timer_off(b0[7]),
    .sys_from_bat(b1[2]), .ldo1_code(b1[1:0]), .ldo2_code(b2[1:0]), .ldo3_code(b2[3:2]),
    .ldo4_code(b2[5:4]), .ldo5_code(b2[7:6]), .wr_pulse(), .wr_index());
  two_wire_assertions two_wire_assertions_i (.core_clk(core_clk), .rstn(rstn), .m_scl_o(link_a.m_scl_o),
    .m_scl_oe(link_a.m_scl_oe), .m_sda_o(link_a.m_sda_o), .m_sda_oe(link_a.m_sda_oe),
    .d_sda_o(link_a.d_sda_o), .d_sda_oe(link_a.d_sda_oe), .scl(link_a.scl), .sda(link_a.sda));
  always #10 core_clk = ~core_clk;
  always @(posedge link_a.scl) sh <= {sh[26:0], link_a.sda};
  // Design outputs are looked at on the falling edge, half a cycle after they settle.
  always @(negedge core_clk) begin
    cyc++;
    if (wr_pulse_a === 1'b1) begin
      wr_seen++;
      wr_idx_last = wr_index_a;
    end
    if (cyc == 6000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk3(input logic [7:0] g0, g1, g2, e0, e1, e2);
    cmp(g0, e0);
    cmp(g1, e1);
    cmp(g2, e2);
  endtask : chk3
  task automatic send(input logic [7:0] r, input logic [7:0] d, input logic exp_nack);
    int n;
    int w0;
    w0 = wr_seen;
    go = 1'b1;
    go_reg = r;
    go_data = d;
    @(negedge core_clk);
    go = 1'b0;
    cmp({7'h00, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    cmp({6'h00, busy, done}, 8'h01);
    cmp({7'h00, nack}, {7'h00, exp_nack});
    cmp(8'(wr_seen - w0), exp_nack ? 8'h00 : 8'h01);
    if (!exp_nack) begin
      cmp(wr_idx_last, r);
      cmp(sh[27:20], 8'h98);
      cmp(sh[18:11], r);
      cmp(sh[9:2], d);
      cmp({5'h00, sh[19], sh[10], sh[1]}, 8'h00);
    end
    @(negedge core_clk);
  endtask : send
  // Quarter periods of the bench-made link clock, two core cycles each.
  task automatic qw(input int q);
    repeat (2 * q) @(negedge core_clk);
  endtask : qw
  task automatic b_bit(input logic v, output logic s);
    qw(1);
    link_b.m_sda_oe = !v;
    qw(1);
    link_b.m_scl_oe = 1'b0;
    qw(1);
    s = link_b.sda;
    qw(1);
    link_b.m_scl_oe = 1'b1;
  endtask : b_bit
  task automatic b_frame(input logic [7:0] ad, rg, dt, output logic [2:0] acks);
    logic s;
    logic [23:0] v;
    v = {ad, rg, dt};
    link_b.m_sda_oe = 1'b1;
    qw(2);
    link_b.m_scl_oe = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      b_bit(v[i], s);
      if (i % 8 == 0) begin
        b_bit(1'b1, s);
        acks[i / 8] = !s;
      end
    end
    qw(1);
    link_b.m_sda_oe = 1'b1;
    qw(1);
    link_b.m_scl_oe = 1'b0;
    qw(2);
    link_b.m_sda_oe = 1'b0;
    qw(2);
  endtask : b_frame
  initial begin
    logic [2:0] acks;
    core_clk = 1'b0;
    rstn = 1'b0;
    cfg_clear = 1'b0;
    go = 1'b0;
    go_reg = 8'h00;
    go_data = 8'h00;
    link_b.m_scl_o = 1'b0;
    link_b.m_scl_oe = 1'b0;
    link_b.m_sda_o = 1'b0;
    link_b.m_sda_oe = 1'b0;
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk3(a0, {5'h00, a1}, a2, 8'h00, 8'h00, 8'h00);
    $display("test reset defaults done");
    send(8'h00, 8'h5c, 1'b0);
    cmp({5'h00, a0[4:2]}, 8'h07);
    send(8'h01, 8'hff, 1'b0);
    send(8'h02, 8'ha5, 1'b0);
    send(8'h03, 8'h3c, 1'b1);
    chk3(a0, {5'h00, a1}, a2, 8'h5c, 8'h07, 8'ha5);
    $display("test writes done");
    repeat (50) @(negedge core_clk);
    chk3(a0, {5'h00, a1}, a2, 8'h5c, 8'h07, 8'ha5);
    cfg_clear = 1'b1;
    @(negedge core_clk);
    cfg_clear = 1'b0;
    @(negedge core_clk);
    chk3(a0, {5'h00, a1}, a2, 8'h00, 8'h00, 8'h00);
    $display("test retention and clear done");
    b_frame(8'h99, 8'h00, 8'hff, acks);
    cmp({5'h00, acks}, 8'h00);
    chk3(b0, {5'h00, b1}, b2, 8'h00, 8'h00, 8'h00);
    b_frame(8'h98, 8'h02, 8'h96, acks);
    cmp({5'h00, acks}, 8'h07);
    chk3(b0, {5'h00, b1}, b2, 8'h00, 8'h00, 8'h96);
    $display("test second link done");
    tally_and_finish();
  end
endmodule : write_only_serial_config_port_bench
